// [verilog/host_port_consts.svh]
/*
  Constants of the host port front end: decode positions, reset values, timing counts.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define CLK_SYS_NS          50
`define RESET_PULSE_NS      200
`define RESET_PULSE_CYC     ((`RESET_PULSE_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`define STRAP_SETTLE_CYC    4
`define ADDR_W              4
`define PICK_BIT_POS        3
`define REG_SEL_W           3
`define ADDR_DLL            3'h0
`define ADDR_DLM            3'h1
`define ADDR_LCR            3'h3
`define DIV_ACCESS_POS      7
`define LCR_RESET           8'h00
`define LEVEL_RESET         8'h00
`define FIFO_DEPTH          128
`define LEGACY_LEVELS       4
`define EXT_LEVELS          128
`define MAX_RATE_EXT_KBPS   5000
`define MAX_RATE_XTAL_KBPS  1500
`endif

// [verilog/host_port_pkg.sv]
/*
  Types shared by the host port front end.
  Assumes host_port_consts.svh on the include path.
*/
`include "host_port_consts.svh"
package host_port_pkg;
  typedef struct packed {
    logic                  chan_a_select_n;
    logic                  chan_b_select_n;
    logic [`ADDR_W-1:0]    addr;
    logic                  rd_n;
    logic                  wr_n;
    logic [7:0]            wdata;
  } host_bus_t;

  typedef struct packed {
    logic [7:0] flow_count_high;
    logic [7:0] flow_count_low;
    logic [7:0] tx_trigger_level;
    logic [7:0] rx_trigger_level;
  } level_regs_t;

  typedef struct packed {
    logic                  sel_a;
    logic                  sel_b;
    logic                  div_access;
    logic [`REG_SEL_W-1:0] reg_sel;
    logic                  rd;
    logic                  wr;
  } chan_access_t;

  typedef enum logic [2:0] {
    PW_RUN   = 3'b001,
    PW_SLEEP = 3'b010,
    PW_RESET = 3'b100
  } power_state_t;
endpackage

// [verilog/pin_sync3.sv]
/*
  Three-flop synchroniser for an input from outside the clock domain.
  The output changes only when the second and third stages agree.
*/
module pin_sync3 (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic reset_val,
  // Pin
  input  wire logic pin,
  output logic      level
);
  logic s1_q, s2_q, s3_q, level_q, level_d;

  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q    <= pin ^ reset_val;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  // Stages hold the difference from the idle level, so reset shows the idle level
  assign level = level_q ^ reset_val;
endmodule // pin_sync3

// [verilog/host_bus_channel_select.sv]
/*
  Host bus front end of a dual-channel serial controller: strap selected bus style,
  channel decode, low-power isolation and wake reset, extended-mode detection.
  Assumes a processor bus as far side; channel internals sit behind the chan ports.
*/
`include "host_port_consts.svh"
module host_bus_channel_select (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Pins
  input  wire logic                        low_power_request,
  input  wire logic                        bus_style_strap,
  input  wire host_port_pkg::host_bus_t    host_bus,
  // Channel register state
  input  wire host_port_pkg::level_regs_t  levels_a,
  input  wire host_port_pkg::level_regs_t  levels_b,
  // Outputs to the channels
  output host_port_pkg::chan_access_t      chan_access,
  output logic                             osc_enable,
  output logic                             bus_isolate,
  output logic                             chan_reset,
  output logic                             split_select_mode,
  output logic                             ext_mode_a,
  output logic                             ext_mode_b,
  output logic [7:0]                       trigger_levels_a,
  output logic [7:0]                       trigger_levels_b
);
  import host_port_pkg::*;

  localparam int RST_W = $clog2(`RESET_PULSE_CYC + 1);

  function automatic logic any_level(input level_regs_t r);
    any_level = |{r.flow_count_high, r.flow_count_low, r.tx_trigger_level, r.rx_trigger_level};
  endfunction

  function automatic logic [7:0] trig_count(input logic ext, input logic [7:0] lvl);
    // Legacy: two-bit selector over four levels; extended: full 1..128
    if (ext)
      trig_count = (lvl[6:0] == 7'h00) ? 8'h80 : {1'b0, lvl[6:0]};
    else
      trig_count = 8'h01 << {lvl[7:6], 1'b0};
  endfunction

  // Low power path
  logic lp_level, strap_level;
  pin_sync3 u_lp_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .reset_val (1'b0),
    .pin       (low_power_request),
    .level     (lp_level)
  );
  pin_sync3 u_strap_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .reset_val (1'b1),
    .pin       (bus_style_strap),
    .level     (strap_level)
  );

  power_state_t          pw_q, pw_d;
  logic [RST_W-1:0]      rcnt_q, rcnt_d;
  logic                  split_q, split_d;
  logic                  strap_taken_q, strap_taken_d;
  logic [2:0]            settle_q, settle_d;

  always_comb begin
    pw_d   = pw_q;
    rcnt_d = rcnt_q;
    unique case (pw_q)
      PW_RUN: begin
        if (lp_level) pw_d = PW_SLEEP;
      end
      PW_SLEEP: begin
        if (!lp_level) begin
          pw_d   = PW_RESET;
          rcnt_d = RST_W'(`RESET_PULSE_CYC);
        end
      end
      PW_RESET: begin
        if (lp_level) pw_d = PW_SLEEP;
        else if (rcnt_q == RST_W'(1)) pw_d = PW_RUN;
        rcnt_d = rcnt_q - RST_W'(1);
      end
    endcase
  end

  always_comb begin
    strap_taken_d = strap_taken_q;
    split_d       = split_q;
    settle_d      = settle_q;
    if (!strap_taken_q) begin
      // Wait until the synchroniser shows the pin's own level
      if (settle_q == 3'(`STRAP_SETTLE_CYC)) begin
        strap_taken_d = 1'b1;
        split_d       = strap_level;
      end else begin
        settle_d = settle_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pw_q          <= PW_RUN;
      rcnt_q        <= '0;
      split_q       <= 1'b1;
      strap_taken_q <= 1'b0;
      settle_q      <= 3'h0;
    end else begin
      pw_q          <= pw_d;
      rcnt_q        <= rcnt_d;
      split_q       <= split_d;
      strap_taken_q <= strap_taken_d;
      settle_q      <= settle_d;
    end
  end

  // Immediate isolation straight from the pin, no clock needed
  assign bus_isolate       = low_power_request | (pw_q == PW_SLEEP);
  assign osc_enable        = ~bus_isolate;
  assign chan_reset        = (pw_q == PW_RESET);
  assign split_select_mode = split_q;

  // Channel decode
  logic [7:0] lcr_a_q, lcr_a_d, lcr_b_q, lcr_b_d;
  logic       sel_a, sel_b, div_acc;

  always_comb begin
    if (split_q) begin
      sel_a = ~host_bus.chan_a_select_n;
      sel_b = ~host_bus.chan_b_select_n;
    end else begin
      sel_a = ~host_bus.chan_a_select_n & ~host_bus.addr[`PICK_BIT_POS];
      sel_b = ~host_bus.chan_a_select_n &  host_bus.addr[`PICK_BIT_POS];
    end
    if (bus_isolate || chan_reset) begin
      sel_a = 1'b0;
      sel_b = 1'b0;
    end
  end

  // Divisor-access bit shadow of each line control register
  always_comb begin
    lcr_a_d = lcr_a_q;
    lcr_b_d = lcr_b_q;
    if (!host_bus.wr_n && host_bus.addr[`REG_SEL_W-1:0] == `ADDR_LCR) begin
      if (sel_a) lcr_a_d = host_bus.wdata;
      if (sel_b) lcr_b_d = host_bus.wdata;
    end
    if (chan_reset) begin
      lcr_a_d = `LCR_RESET;
      lcr_b_d = `LCR_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lcr_a_q <= `LCR_RESET;
      lcr_b_q <= `LCR_RESET;
    end else begin
      lcr_a_q <= lcr_a_d;
      lcr_b_q <= lcr_b_d;
    end
  end

  assign div_acc = sel_a ? lcr_a_q[`DIV_ACCESS_POS] : lcr_b_q[`DIV_ACCESS_POS];

  // Access strobe to channels; divisor view only at offsets 0 and 1 with access bit
  always_comb begin
    chan_access.sel_a      = sel_a;
    chan_access.sel_b      = sel_b;
    chan_access.reg_sel    = host_bus.addr[`REG_SEL_W-1:0];
    chan_access.div_access = div_acc &
                             (host_bus.addr[`REG_SEL_W-1:0] == `ADDR_DLL ||
                              host_bus.addr[`REG_SEL_W-1:0] == `ADDR_DLM);
    chan_access.rd         = (sel_a | sel_b) & ~host_bus.rd_n;
    chan_access.wr         = (sel_a | sel_b) & ~host_bus.wr_n;
  end

  // Extended mode and effective trigger levels, registered
  logic       ext_a_q, ext_a_d, ext_b_q, ext_b_d;
  logic [7:0] trig_a_q, trig_a_d, trig_b_q, trig_b_d;

  always_comb begin
    ext_a_d  = any_level(levels_a) & ~chan_reset;
    ext_b_d  = any_level(levels_b) & ~chan_reset;
    trig_a_d = trig_count(ext_a_d, levels_a.rx_trigger_level);
    trig_b_d = trig_count(ext_b_d, levels_b.rx_trigger_level);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_a_q  <= 1'b0;
      ext_b_q  <= 1'b0;
      trig_a_q <= 8'h01;
      trig_b_q <= 8'h01;
    end else begin
      ext_a_q  <= ext_a_d;
      ext_b_q  <= ext_b_d;
      trig_a_q <= trig_a_d;
      trig_b_q <= trig_b_d;
    end
  end

  assign ext_mode_a       = ext_a_q;
  assign ext_mode_b       = ext_b_q;
  assign trigger_levels_a = trig_a_q;
  assign trigger_levels_b = trig_b_q;
  // FIFO size, framing, parity and rate limits live in the channel blocks
endmodule // host_bus_channel_select

// [tb/host_cpu_model.sv]
/*
  Processor bus model that drives the host port pins.
  Assumes the bench calls its tasks; all pins change at the falling edge.
*/
module host_cpu_model (
  // Clock
  input  wire logic                clk_sys,
  // Bus
  output host_port_pkg::host_bus_t host_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_bus = '1;
  // One bus phase: select, address and strobe held until the next call
  task put(input logic ca, input logic cb, input logic [3:0] a, input logic w,
           input logic [7:0] d);
    @(negedge clk_sys);
    host_bus.chan_a_select_n = ca;
    host_bus.chan_b_select_n = cb;
    host_bus.addr            = a;
    host_bus.rd_n            = w;
    host_bus.wr_n            = !w;
    host_bus.wdata           = w ? d : ~host_bus.wdata;
  endtask
endmodule // host_cpu_model

// [tb/host_port_assertions.sv]
/*
  Checker of the host port front end.
  Assumes it is bound to host_bus_channel_select.
*/
`include "host_port_consts.svh"
module host_port_checker (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        low_power_request,
  input wire logic                        bus_style_strap,
  input wire host_port_pkg::host_bus_t    host_bus,
  input wire host_port_pkg::level_regs_t  levels_a,
  input wire host_port_pkg::level_regs_t  levels_b,
  input wire host_port_pkg::chan_access_t chan_access,
  input wire logic                        osc_enable,
  input wire logic                        bus_isolate,
  input wire logic                        chan_reset,
  input wire logic                        split_select_mode,
  input wire logic                        ext_mode_a,
  input wire logic                        ext_mode_b,
  input wire logic [7:0]                  trigger_levels_a,
  input wire logic [7:0]                  trigger_levels_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_ISOLATE_NOW: assert property (low_power_request |-> bus_isolate)
    else $error("bus not isolated under low power request");
  AST_OSC_STOP: assert property (low_power_request [*5] |-> !osc_enable)
    else $error("oscillator still enabled in low power");
  AST_STAY_LOW: assert property (low_power_request && !osc_enable |=> !osc_enable)
    else $error("left low power while request held");
  AST_WAKE_RESET: assert property ($fell(low_power_request) |-> ##[1:6] chan_reset)
    else $error("no reset after low power release");
  AST_RESET_LEN: assert property ($rose(chan_reset) |-> chan_reset [*4] ##1 !chan_reset)
    else $error("wake reset pulse length wrong");
  AST_REFUSE: assert property (bus_isolate || chan_reset |-> !chan_access.sel_a
    && !chan_access.sel_b)
    else $error("channel selected while isolated");
  AST_SPLIT: assert property (split_select_mode && !bus_isolate && !chan_reset |->
    chan_access.sel_a == !host_bus.chan_a_select_n
    && chan_access.sel_b == !host_bus.chan_b_select_n)
    else $error("split select decode wrong");
  AST_SHARED: assert property (!split_select_mode && !bus_isolate && !chan_reset |->
    chan_access.sel_a == (!host_bus.chan_a_select_n && !host_bus.addr[`PICK_BIT_POS])
    && chan_access.sel_b == (!host_bus.chan_a_select_n && host_bus.addr[`PICK_BIT_POS]))
    else $error("shared select decode wrong");
  AST_EXT_ON: assert property ((|levels_a) [*2] |-> ext_mode_a)
    else $error("extended mode missing");
  AST_EXT_OFF: assert property ((levels_b == '0) [*2] |-> !ext_mode_b)
    else $error("extended mode with zero levels");
endmodule // host_port_checker
bind host_bus_channel_select host_port_checker chk (.clk_sys, .rst, .low_power_request,
  .bus_style_strap, .host_bus, .levels_a, .levels_b, .chan_access, .osc_enable,
  .bus_isolate, .chan_reset, .split_select_mode, .ext_mode_a, .ext_mode_b,
  .trigger_levels_a, .trigger_levels_b);

// [tb/tb.sv]
/*
  Bench of the host port front end: decode, low power, extended mode.
  Assumes the processor model and the bound checker.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import host_port_pkg::*;
  logic         clk_sys = 0, rst = 1, low_power_request = 0, bus_style_strap = 1;
  host_bus_t    host_bus;
  level_regs_t  levels_a = '0, levels_b = '0;
  chan_access_t chan_access;
  logic         osc_enable, bus_isolate, chan_reset, split_select_mode;
  logic         ext_mode_a, ext_mode_b;
  logic [7:0]   trigger_levels_a, trigger_levels_b;
  integer       miscompares = 0, n_compared = 0, n, i;
  always #25 clk_sys = ~clk_sys;
  host_cpu_model cpu (.clk_sys, .host_bus);
  host_bus_channel_select DUT (.clk_sys, .rst, .low_power_request, .bus_style_strap,
    .host_bus, .levels_a, .levels_b, .chan_access, .osc_enable, .bus_isolate,
    .chan_reset, .split_select_mode, .ext_mode_a, .ext_mode_b, .trigger_levels_a,
    .trigger_levels_b);
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task reset_dut(input logic s);
    @(negedge clk_sys);
    bus_style_strap = s;
    rst = 1;
    repeat (2) @(negedge clk_sys);
    rst = 0;
    repeat (6) @(negedge clk_sys);
  endtask
  task probe(input logic ca, input logic cb, input logic [3:0] a, input logic ea,
             input logic eb);
    cpu.put(ca, cb, a, 1'b0, 8'h00);
    #1;
    check("sel_a", {7'h0, chan_access.sel_a}, {7'h0, ea});
    check("sel_b", {7'h0, chan_access.sel_b}, {7'h0, eb});
    check("rd", {7'h0, chan_access.rd}, {7'h0, ea | eb});
    check("reg_sel", {5'h0, chan_access.reg_sel}, {5'h0, a[2:0]});
  endtask
  initial begin
    #100000;
    miscompares++;
    close_out;
  end
  initial begin
    reset_dut(1'b1);
    check("split", {7'h0, split_select_mode}, 8'h01);
    for (i = 0; i < 4; i++) probe(i[0], i[1], 4'h8, !i[0], !i[1]);
    cpu.put(1'b0, 1'b1, 4'h3, 1'b1, 8'h80);
    #1;
    check("wr", {7'h0, chan_access.wr}, 8'h01);
    check("rd", {7'h0, chan_access.rd}, 8'h00);
    probe(1'b0, 1'b1, 4'h0, 1'b1, 1'b0);
    check("div", {7'h0, chan_access.div_access}, 8'h01);
    cpu.put(1'b0, 1'b1, 4'h3, 1'b1, 8'h00);
    probe(1'b0, 1'b1, 4'h0, 1'b1, 1'b0);
    check("div", {7'h0, chan_access.div_access}, 8'h00);
    check("ext_a", {7'h0, ext_mode_a}, 8'h00);
    check("trig_a", trigger_levels_a, 8'h01);
    levels_a.rx_trigger_level = 8'h05;
    levels_b.flow_count_low = 8'h01;
    repeat (3) @(negedge clk_sys);
    check("ext_a", {7'h0, ext_mode_a}, 8'h01);
    check("trig_a", trigger_levels_a, 8'h05);
    check("ext_b", {7'h0, ext_mode_b}, 8'h01);
    check("trig_b", trigger_levels_b, 8'h80);
    levels_a = '0;
    levels_b = '0;
    repeat (3) @(negedge clk_sys);
    check("ext_b", {7'h0, ext_mode_b}, 8'h00);
    cpu.put(1'b0, 1'b1, 4'h3, 1'b1, 8'h80);
    cpu.put(1'b0, 1'b0, 4'h0, 1'b0, 8'h00);
    low_power_request = 1;
    #1;
    check("iso", {7'h0, bus_isolate}, 8'h01);
    check("sel_a", {7'h0, chan_access.sel_a}, 8'h00);
    repeat (6) @(negedge clk_sys);
    check("osc", {7'h0, osc_enable}, 8'h00);
    repeat (20) @(negedge clk_sys);
    check("osc", {7'h0, osc_enable}, 8'h00);
    low_power_request = 0;
    n = 0;
    for (i = 0; i < 10 && chan_reset !== 1'b1; i++) @(negedge clk_sys);
    while (chan_reset === 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    check("reset_len", n[7:0], 8'h04);
    repeat (2) @(negedge clk_sys);
    check("osc", {7'h0, osc_enable}, 8'h01);
    probe(1'b0, 1'b1, 4'h0, 1'b1, 1'b0);
    check("div", {7'h0, chan_access.div_access}, 8'h00);
    reset_dut(1'b0);
    check("split", {7'h0, split_select_mode}, 8'h00);
    for (i = 0; i < 4; i++) probe(i[0], 1'b1, {i[1], 3'h0}, !i[0] && !i[1], !i[0] && i[1]);
    close_out;
  end
endmodule // tb
